/* File: dv/ajrl_spool_model.sv */
// behavioural spool control that follows the ramp-limited set-point
`timescale 1ns/10ps
module ajrl_spool_model #(
	parameter logic signed [12:0] SPOOL_STEP = 13'sh032
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [ajrl_pkg::FLOW_W-1:0] spool_setpoint,
	output logic signed [12:0] spool_pos
);
	import ajrl_pkg::*;
	logic signed [12:0] tgt;
	assign tgt = 13'(signed'(spool_setpoint));
	// the main spool has its own slew limit, so it lags fast set-point jumps
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			spool_pos <= 13'sh000;
		end else if (tgt > spool_pos + SPOOL_STEP) begin
			spool_pos <= spool_pos + SPOOL_STEP;
		end else if (tgt < spool_pos - SPOOL_STEP) begin
			spool_pos <= spool_pos - SPOOL_STEP;
		end else begin
			spool_pos <= tgt;
		end
	end
endmodule

/* File: dv/tb.sv */
// self-checking bench for the anti-jerk ramp limiter
`timescale 1ns/10ps
module tb;
	import ajrl_pkg::*;
	localparam int TK = 16;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [FLOW_W-1:0] req = '0;
	logic [PAR_W-1:0] speed = '0;
	ajrl_bus_t bus = '0;
	logic [DATA_W-1:0] rd_data;
	logic [FLOW_W-1:0] spool_setpoint;
	ajrl_phase_t ramp_phase;
	logic abort_active;
	logic signed [12:0] spool_pos;
	logic rd_d = 1'b0;
	logic [DATA_W-1:0] exp_q[$];
	string nm_q[$];
	int failures = 0;
	int check_count = 0;
	logic [15:0] dflt [15] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h015e,
		16'h00c8, 16'h015e, 16'h01f4, 16'h03e8, 16'h0064, 16'h0000, 16'h0001,
		16'h0000, 16'h0000, 16'h0000};
	// 10 ms rise, 20 ms falls, fast fall and abort off, linear curves
	logic [15:0] base [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h0014,
		16'h000a, 16'h0014, 16'h0064, 16'h03e8, 16'h000a, 16'h03e8, 16'h0005};
	int spd [3] = '{0, 50, 200};
	int stp [3] = '{50, 66, 100};
	int athr [4] = '{0, 100, 300, 1000};
	int arev [4] = '{-1, -200, -200, -200};
	bit ab [4] = '{1, 1, 0, 0};
	int v;

	always #4 sys_clk = ~sys_clk;

	ajrl_limiter #(.TICK_CYCLES(TK)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.requested_port_flow(req), .vehicle_speed(speed), .bus_in(bus),
		.rd_data(rd_data), .spool_setpoint(spool_setpoint),
		.ramp_phase(ramp_phase), .abort_active(abort_active));
	ajrl_spool_model u_spool (.sys_clk(sys_clk), .reset_n(reset_n),
		.spool_setpoint(spool_setpoint), .spool_pos(spool_pos));

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// read data stand only in the cycle after the read strobe
	always @(posedge sys_clk) begin
		if (rd_d && exp_q.size() > 0) begin
			chk(nm_q.pop_front(), exp_q.pop_front(), rd_data);
		end
		rd_d <= bus.rd;
	end

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
		@(posedge sys_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		exp_q.push_back(e);
		nm_q.push_back(nm);
		@(posedge sys_clk);
		bus.rd <= 1'b0;
	endtask

	task automatic rflow(input int e);
		rd(OFS_FLOW, 16'(e), "flow");
	endtask

	task automatic waitt(input int k);
		repeat (k * TK) @(posedge sys_clk);
	endtask

	// wait for the next set-point step, which aligns the bench to the tick
	task automatic wchg;
		logic [FLOW_W-1:0] p;
		int n;
		p = spool_setpoint;
		n = 0;
		while (spool_setpoint === p && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 400) begin
			failures++;
			$display("mismatch setpoint expected step seen none");
		end
	endtask

	task automatic prep(input int r);
		wr(OFS_RAMP_TYPE, 16'h0000);
		@(posedge sys_clk);
		req <= 12'(r);
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic go(input logic [15:0] m, input int r);
		wr(OFS_RAMP_TYPE, m);
		@(posedge sys_clk);
		req <= 12'(r);
		wchg();
	endtask

	task automatic tend(input string nm);
		repeat (3) @(posedge sys_clk);
		$display("test %s done", nm);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge sys_clk);
		failures++;
		finish_test();
	end

	initial begin
		void'($urandom(32'h47fc));
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 15; i++) begin
			rd(4'(i), dflt[i], $sformatf("reg%0h", i));
		end
		tend("defaults");
		for (int i = 3; i < 12; i++) begin
			v = int'($urandom_range(1000, 1));
			wr(4'(i), 16'(v));
			rd(4'(i), 16'(v), $sformatf("reg%0h", i));
		end
		for (int i = 0; i < 3; i++) begin
			v = int'($urandom_range(2000)) - 1000;
			prep(v);
			rflow(v);
		end
		tend("registers and bypass");
		for (int i = 1; i < 12; i++) begin
			wr(4'(i), base[i]);
		end
		for (int s = 1; s >= -1; s -= 2) begin
			prep(0);
			go(16'h0001, 1000 * s);
			rflow(100 * s);
			rd(OFS_STATUS, 16'h0001, "status");
			chk("phase", 16'h0001, 16'(ramp_phase));
			waitt(2);
			rflow(300 * s);
			waitt(8);
			rflow(1000 * s);
			chk("spool", 16'(1000 * s), 16'(spool_pos));
			rd(OFS_STATUS, 16'h0000, "status");
		end
		tend("fixed rise");
		prep(1000);
		go(16'h0001, 0);
		rflow(950);
		rd(OFS_STATUS, 16'h0002, "status");
		waitt(2);
		rflow(850);
		wr(OFS_FAST_THR, 16'h0320);
		prep(1000);
		go(16'h0001, 0);
		rflow(900);
		rd(OFS_STATUS, 16'h0003, "status");
		chk("phase", 16'h0003, 16'(ramp_phase));
		waitt(2);
		rflow(750);
		rd(OFS_STATUS, 16'h0002, "status");
		wr(OFS_FAST_THR, 16'h03e8);
		tend("falls");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_ABORT_THR, 16'(athr[i]));
			prep(500);
			go(16'h0001, 0);
			@(posedge sys_clk);
			req <= 12'(arev[i]);
			waitt(2);
			rd(OFS_STATUS, ab[i] ? 16'h000c : 16'h0002, "status");
			chk("abort", 16'(ab[i]), 16'(abort_active));
			if (!ab[i]) begin
				rflow(350);
			end
		end
		tend("abort");
		wr(OFS_RISE_T0, 16'h0014);
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			speed <= 10'(spd[i]);
			prep(0);
			go(16'h0002, 1000);
			rflow(stp[i]);
		end
		tend("speed");
		wr(OFS_RISE_T0, 16'h000a);
		wr(OFS_RISE_LIN, 16'h000a);
		prep(0);
		go(16'h0001, 1000);
		rflow(19);
		waitt(4);
		rflow(113);
		wr(OFS_FALL_T0, 16'h000a);
		wr(OFS_FALL_LIN, 16'h000a);
		prep(1000);
		go(16'h0001, 0);
		rflow(734);
		tend("curves");
		finish_test();
	end
endmodule

/* File: hdl/ajrl_limiter.sv */
// anti-jerk ramp limiter between steering flow request and spool set-point
`timescale 1ns/10ps
module ajrl_limiter #(
	parameter int TICK_CYCLES = ajrl_pkg::TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [ajrl_pkg::FLOW_W-1:0] requested_port_flow,
	input wire logic [ajrl_pkg::PAR_W-1:0] vehicle_speed,
	input wire ajrl_pkg::ajrl_bus_t bus_in,
	output logic [ajrl_pkg::DATA_W-1:0] rd_data,
	output logic [ajrl_pkg::FLOW_W-1:0] spool_setpoint,
	output ajrl_pkg::ajrl_phase_t ramp_phase,
	output logic abort_active
);
	import ajrl_pkg::*;

	function automatic logic [PAR_W-1:0] min1(input logic [PAR_W-1:0] t);
		min1 = (t == '0) ? 10'h001 : t;
	endfunction

	function automatic logic [PAR_W-1:0] interp(input logic [PAR_W-1:0] t0,
		input logic [PAR_W-1:0] th, input logic [PAR_W-1:0] v, input logic [PAR_W-1:0] rng);
		int vc;
		int r;
		vc = (v > rng) ? int'(rng) : int'(v);
		if (rng == '0) begin
			r = int'(th);
		end else begin
			r = int'(t0) + ((int'(th) - int'(t0)) * vc) / int'(rng);
		end
		interp = PAR_W'(r);
	endfunction

	function automatic int seg_slope(input logic [PAR_W-1:0] pos, input logic [3:0] lin);
		int s;
		int l;
		l = (int'(lin) > LIN_MAX) ? LIN_MAX : int'(lin);
		if (pos < BREAK_0) begin
			s = SLOPE_S0;
		end else if (pos < BREAK_1) begin
			s = SLOPE_S1;
		end else if (pos < BREAK_2) begin
			s = SLOPE_S2;
		end else begin
			s = SLOPE_S3;
		end
		seg_slope = SLOPE_LIN + ((s - SLOPE_LIN) * l) / LIN_MAX;
	endfunction

	// two-stage synchronisers for the request and speed pins
	logic [FLOW_W-1:0] req_meta_reg;
	logic [FLOW_W-1:0] req_sync_reg;
	logic [PAR_W-1:0] spd_meta_reg;
	logic [PAR_W-1:0] spd_sync_reg;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			req_meta_reg <= '0;
			req_sync_reg <= '0;
			spd_meta_reg <= '0;
			spd_sync_reg <= '0;
		end else begin
			req_meta_reg <= requested_port_flow;
			req_sync_reg <= req_meta_reg;
			spd_meta_reg <= vehicle_speed;
			spd_sync_reg <= spd_meta_reg;
		end
	end

	// control tick divider
	logic [31:0] tick_cnt_reg;
	logic [31:0] tick_cnt_next;
	logic tick_reg;
	logic tick_next;
	always_comb begin
		tick_next = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
		tick_cnt_next = tick_next ? '0 : tick_cnt_reg + 32'h1;
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			tick_reg <= tick_next;
		end
	end

	// register file
	ajrl_cfg_t cfg_reg;
	ajrl_cfg_t cfg_next;
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;
	logic [FLOW_W-1:0] out_reg;
	ajrl_phase_t phase_reg;
	logic abort_reg;
	always_comb begin
		cfg_next = cfg_reg;
		rd_data_next = '0;
		if (bus_in.wr) begin
			unique case (bus_in.addr)
				OFS_RAMP_TYPE: cfg_next.ramp_type_select = bus_in.wdata[1:0];
				OFS_RISE_LIN: cfg_next.rise_curve_linearity = bus_in.wdata[3:0];
				OFS_FALL_LIN: cfg_next.slow_fall_curve_linearity = bus_in.wdata[3:0];
				OFS_RISE_T0: cfg_next.rise_t0 = bus_in.wdata[PAR_W-1:0];
				OFS_FALL_T0: cfg_next.fall_t0 = bus_in.wdata[PAR_W-1:0];
				OFS_RISE_TH: cfg_next.rise_th = bus_in.wdata[PAR_W-1:0];
				OFS_FALL_TH: cfg_next.fall_th = bus_in.wdata[PAR_W-1:0];
				OFS_SPEED_RANGE: cfg_next.speed_range = bus_in.wdata[PAR_W-1:0];
				OFS_FAST_THR: cfg_next.fast_fall_threshold = bus_in.wdata[PAR_W-1:0];
				OFS_FAST_T: cfg_next.fast_t = bus_in.wdata[PAR_W-1:0];
				OFS_ABORT_THR: cfg_next.reverse_abort_threshold = bus_in.wdata[PAR_W-1:0];
				OFS_ABORT_T: cfg_next.abort_t = bus_in.wdata[PAR_W-1:0];
				default: ;
			endcase
		end
		if (bus_in.rd) begin
			unique case (bus_in.addr)
				OFS_RAMP_TYPE: rd_data_next = DATA_W'(cfg_reg.ramp_type_select);
				OFS_RISE_LIN: rd_data_next = DATA_W'(cfg_reg.rise_curve_linearity);
				OFS_FALL_LIN: rd_data_next = DATA_W'(cfg_reg.slow_fall_curve_linearity);
				OFS_RISE_T0: rd_data_next = DATA_W'(cfg_reg.rise_t0);
				OFS_FALL_T0: rd_data_next = DATA_W'(cfg_reg.fall_t0);
				OFS_RISE_TH: rd_data_next = DATA_W'(cfg_reg.rise_th);
				OFS_FALL_TH: rd_data_next = DATA_W'(cfg_reg.fall_th);
				OFS_SPEED_RANGE: rd_data_next = DATA_W'(cfg_reg.speed_range);
				OFS_FAST_THR: rd_data_next = DATA_W'(cfg_reg.fast_fall_threshold);
				OFS_FAST_T: rd_data_next = DATA_W'(cfg_reg.fast_t);
				OFS_ABORT_THR: rd_data_next = DATA_W'(cfg_reg.reverse_abort_threshold);
				OFS_ABORT_T: rd_data_next = DATA_W'(cfg_reg.abort_t);
				OFS_STATUS: rd_data_next = DATA_W'({abort_reg, phase_reg});
				OFS_FLOW: rd_data_next = DATA_W'(signed'(out_reg));
				default: rd_data_next = '0;
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_reg <= '{RST_RAMP_TYPE, RST_LIN, RST_LIN, RST_RISE_T0, RST_FALL_T0,
				RST_RISE_TH, RST_FALL_TH, RST_SPEED_RANGE, RST_FAST_THR, RST_FAST_T,
				RST_ABORT_THR, RST_ABORT_T};
			rd_data_reg <= '0;
		end else begin
			cfg_reg <= cfg_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// ramp engine
	logic signed [FLOW_W-1:0] req_s;
	logic [PAR_W-1:0] mag_req;
	logic [PAR_W-1:0] mag_out;
	logic [PAR_W-1:0] t_up_eff;
	logic [PAR_W-1:0] t_dn_eff;
	logic [PAR_W-1:0] t_sel;
	logic [PAR_W-1:0] dn_target;
	logic [3:0] lin_sel;
	logic same_dir;
	logic rising;
	logic falling;
	logic fast_zone;
	logic reverse_hit;
	logic [11:0] step;
	logic [PAR_W-1:0] mag_new;
	logic [FLOW_W-1:0] out_next;
	ajrl_phase_t phase_next;
	logic abort_next;
	always_comb begin
		int base;
		int stp;
		base = 0;
		stp = 0;
		// clamp request to full scale either way
		if ($signed(req_sync_reg) > $signed({2'b00, FULL_SCALE})) begin
			req_s = FLOW_W'(FULL_SCALE);
		end else if ($signed(req_sync_reg) < -$signed({2'b00, FULL_SCALE})) begin
			req_s = -$signed({2'b00, FULL_SCALE});
		end else begin
			req_s = req_sync_reg;
		end
		mag_req = PAR_W'(req_s[FLOW_W-1] ? -req_s : req_s);
		mag_out = PAR_W'(out_reg[FLOW_W-1] ? -$signed(out_reg) : $signed(out_reg));
		unique case (cfg_reg.ramp_type_select)
			AJRL_SPEED: begin
				t_up_eff = min1(interp(min1(cfg_reg.rise_t0), min1(cfg_reg.rise_th),
					spd_sync_reg, cfg_reg.speed_range));
				t_dn_eff = min1(interp(min1(cfg_reg.fall_t0), min1(cfg_reg.fall_th),
					spd_sync_reg, cfg_reg.speed_range));
			end
			default: begin
				t_up_eff = min1(cfg_reg.rise_t0);
				t_dn_eff = min1(cfg_reg.fall_t0);
			end
		endcase
		same_dir = (out_reg == '0) || (out_reg[FLOW_W-1] == req_s[FLOW_W-1]) && (req_s != '0);
		rising = same_dir && (mag_req > mag_out);
		dn_target = same_dir ? mag_req : '0;
		falling = (mag_out > dn_target) && !rising;
		fast_zone = (cfg_reg.fast_fall_threshold < FULL_SCALE)
			&& (mag_out > cfg_reg.fast_fall_threshold);
		reverse_hit = !same_dir && (req_s != '0) && (mag_req > cfg_reg.reverse_abort_threshold)
			&& (cfg_reg.reverse_abort_threshold != ABORT_OFF);
		abort_next = abort_reg;
		if (cfg_reg.ramp_type_select == AJRL_BYPASS || cfg_reg.reverse_abort_threshold == ABORT_OFF) begin
			abort_next = 1'b0;
		end else if (tick_reg) begin
			if (falling && !abort_reg && !fast_zone && reverse_hit) begin
				abort_next = 1'b1;
			end else if (!falling) begin
				abort_next = 1'b0;
			end
		end
		if (rising) begin
			t_sel = t_up_eff;
			lin_sel = cfg_reg.rise_curve_linearity;
			phase_next = PH_RISE;
		end else if (falling && abort_reg) begin
			t_sel = min1(cfg_reg.abort_t);
			lin_sel = '0;
			phase_next = PH_ABORT;
		end else if (falling && fast_zone) begin
			t_sel = min1(cfg_reg.fast_t);
			lin_sel = '0;
			phase_next = PH_FAST;
		end else begin
			t_sel = t_dn_eff;
			lin_sel = cfg_reg.slow_fall_curve_linearity;
			phase_next = falling ? PH_SLOW : PH_HOLD;
		end
		// full-scale move per tick over the selected time, bent per curve segment
		base = (int'(FULL_SCALE) * TICK_PERIOD_US) / (1000 * int'(t_sel));
		stp = (base * seg_slope(mag_out, lin_sel)) / SLOPE_LIN;
		stp = (stp < 1) ? 1 : ((stp > STEP_MAX) ? STEP_MAX : stp);
		step = 12'(stp);
		if (rising) begin
			mag_new = (12'(mag_out) + step >= 12'(mag_req)) ? mag_req : PAR_W'(12'(mag_out) + step);
		end else if (falling) begin
			mag_new = (12'(mag_out) <= 12'(dn_target) + step) ? dn_target
				: PAR_W'(12'(mag_out) - step);
		end else begin
			mag_new = mag_out;
		end
		out_next = out_reg;
		if (cfg_reg.ramp_type_select == AJRL_BYPASS) begin
			out_next = req_s;
			phase_next = PH_HOLD;
		end else if (tick_reg) begin
			// rising takes the request's sign, falling keeps the present one
			if (rising ? req_s[FLOW_W-1] : out_reg[FLOW_W-1]) begin
				out_next = -$signed({2'b00, mag_new});
			end else begin
				out_next = {2'b00, mag_new};
			end
		end else begin
			phase_next = phase_reg;
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_reg <= '0;
			phase_reg <= PH_HOLD;
			abort_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
			phase_reg <= phase_next;
			abort_reg <= abort_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign spool_setpoint = out_reg;
	assign ramp_phase = phase_reg;
	assign abort_active = abort_reg;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_bypass_follow: assert property (
		cfg_reg.ramp_type_select == AJRL_BYPASS ##1 cfg_reg.ramp_type_select == AJRL_BYPASS
		|-> out_reg == $past(req_s)) else $error("bypass output does not follow request");
	a_fixed_times: assert property (
		cfg_reg.ramp_type_select == AJRL_FIXED && cfg_reg.rise_t0 != '0
		|-> t_up_eff == cfg_reg.rise_t0) else $error("fixed rise time not applied");
	a_speed_high: assert property (
		cfg_reg.ramp_type_select == AJRL_SPEED && cfg_reg.speed_range != '0
		&& spd_sync_reg >= cfg_reg.speed_range && cfg_reg.fall_th != '0
		|-> t_dn_eff == cfg_reg.fall_th) else $error("high-speed fall time not applied");
	a_speed_zero: assert property (
		cfg_reg.ramp_type_select == AJRL_SPEED && spd_sync_reg == '0
		&& cfg_reg.speed_range != '0 && cfg_reg.rise_t0 != '0
		|-> t_up_eff == cfg_reg.rise_t0) else $error("standstill rise time not applied");
	a_step_bound: assert property (
		cfg_reg.ramp_type_select != AJRL_BYPASS ##1 cfg_reg.ramp_type_select != AJRL_BYPASS
		|-> ($signed(out_reg) - $signed($past(out_reg)) <= $signed({1'b0, $past(step)}))
		&& ($signed($past(out_reg)) - $signed(out_reg) <= $signed({1'b0, $past(step)})))
		else $error("output moved more than one step");
	a_hold_between: assert property (
		!tick_reg && cfg_reg.ramp_type_select != AJRL_BYPASS ##1
		cfg_reg.ramp_type_select != AJRL_BYPASS |-> $stable(out_reg))
		else $error("output moved between ticks");
	a_linear_shape: assert property (
		lin_sel == '0 ##1 lin_sel == '0 && $stable(t_sel) |-> $stable(step))
		else $error("linear curve bent");
	a_fast_select: assert property (
		falling && !abort_reg && fast_zone && cfg_reg.fast_t != '0 |-> t_sel == cfg_reg.fast_t)
		else $error("fast fall time not selected");
	a_abort_set: assert property (
		tick_reg && cfg_reg.ramp_type_select != AJRL_BYPASS && falling && !fast_zone
		&& reverse_hit |=> abort_reg) else $error("reverse request did not abort");
	a_abort_off: assert property (
		cfg_reg.reverse_abort_threshold == ABORT_OFF |=> !abort_reg)
		else $error("abort active while disabled");
	c_rise: cover property (phase_reg == PH_RISE ##1 phase_reg == PH_HOLD);
	c_fast_slow: cover property (phase_reg == PH_FAST ##[1:1000] phase_reg == PH_SLOW);
	c_abort: cover property (phase_reg == PH_SLOW ##[1:1000] phase_reg == PH_ABORT);
endmodule

/* File: hdl/ajrl_pkg.sv */
// constants, types and register map of the anti-jerk ramp limiter
package ajrl_pkg;
	localparam int CLK_FREQ_KHZ = 125000;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES = CLK_FREQ_KHZ * TICK_PERIOD_US / 1000;
	localparam int FLOW_W = 12;
	localparam int PAR_W = 10;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam logic [PAR_W-1:0] FULL_SCALE = 10'h3e8;
	localparam logic [PAR_W-1:0] ABORT_OFF = 10'h3e8;
	// slope breakpoints on the flow axis
	localparam logic [PAR_W-1:0] BREAK_0 = 10'h032;
	localparam logic [PAR_W-1:0] BREAK_1 = 10'h078;
	localparam logic [PAR_W-1:0] BREAK_2 = 10'h14d;
	// segment slopes of the most progressive curve, 256 = linear
	localparam int SLOPE_LIN = 256;
	localparam int SLOPE_S0 = 51;
	localparam int SLOPE_S1 = 72;
	localparam int SLOPE_S2 = 218;
	localparam int SLOPE_S3 = 683;
	localparam int LIN_MAX = 10;
	localparam int STEP_MAX = 2000;
	// register word offsets
	localparam logic [ADDR_W-1:0] OFS_RAMP_TYPE = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_RISE_LIN = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_FALL_LIN = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_RISE_T0 = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_FALL_T0 = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_RISE_TH = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_FALL_TH = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_SPEED_RANGE = 4'h7;
	localparam logic [ADDR_W-1:0] OFS_FAST_THR = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_FAST_T = 4'h9;
	localparam logic [ADDR_W-1:0] OFS_ABORT_THR = 4'ha;
	localparam logic [ADDR_W-1:0] OFS_ABORT_T = 4'hb;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;
	localparam logic [ADDR_W-1:0] OFS_FLOW = 4'hd;
	// values after reset
	localparam logic [1:0] RST_RAMP_TYPE = 2'h0;
	localparam logic [3:0] RST_LIN = 4'h0;
	localparam logic [PAR_W-1:0] RST_RISE_T0 = 10'h001;
	localparam logic [PAR_W-1:0] RST_FALL_T0 = 10'h15e;
	localparam logic [PAR_W-1:0] RST_RISE_TH = 10'h0c8;
	localparam logic [PAR_W-1:0] RST_FALL_TH = 10'h15e;
	localparam logic [PAR_W-1:0] RST_SPEED_RANGE = 10'h1f4;
	localparam logic [PAR_W-1:0] RST_FAST_THR = 10'h3e8;
	localparam logic [PAR_W-1:0] RST_FAST_T = 10'h064;
	localparam logic [PAR_W-1:0] RST_ABORT_THR = 10'h000;
	localparam logic [PAR_W-1:0] RST_ABORT_T = 10'h001;

	typedef enum logic [1:0] {
		AJRL_BYPASS = 2'b00,
		AJRL_FIXED = 2'b01,
		AJRL_SPEED = 2'b10
	} ajrl_mode_t;

	typedef enum logic [2:0] {
		PH_HOLD = 3'b000,
		PH_RISE = 3'b001,
		PH_SLOW = 3'b010,
		PH_FAST = 3'b011,
		PH_ABORT = 3'b100
	} ajrl_phase_t;

	typedef struct packed {
		logic [1:0] ramp_type_select;
		logic [3:0] rise_curve_linearity;
		logic [3:0] slow_fall_curve_linearity;
		logic [PAR_W-1:0] rise_t0;
		logic [PAR_W-1:0] fall_t0;
		logic [PAR_W-1:0] rise_th;
		logic [PAR_W-1:0] fall_th;
		logic [PAR_W-1:0] speed_range;
		logic [PAR_W-1:0] fast_fall_threshold;
		logic [PAR_W-1:0] fast_t;
		logic [PAR_W-1:0] reverse_abort_threshold;
		logic [PAR_W-1:0] abort_t;
	} ajrl_cfg_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ajrl_bus_t;
endpackage
